// File: pmdb_pkg.sv
/*
  Package for the peripheral module disable bank: register offsets,
  reset values, field positions and timing.
  Assumes a byte-wide register port on the system clock.
*/
package pmdb_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 8;
  localparam logic [11:0] OFS_CTRL_A     = 12'h063;
  localparam logic [11:0] OFS_CTRL_B     = 12'h064;
  localparam logic [11:0] OFS_CTRL_C     = 12'h065;
  localparam logic [11:0] OFS_CTRL_D     = 12'h066;
  localparam logic [11:0] OFS_CTRL_E     = 12'h067;
  localparam logic [11:0] OFS_CTRL_F     = 12'h068;
  localparam logic [7:0]  RST_CTRL       = 8'h00;
  localparam logic [7:0]  MASK_CTRL_A    = 8'hFB;
  localparam logic [7:0]  MASK_CTRL_F    = 8'h03;
  localparam logic [7:0]  READ_ZERO      = 8'h00;
  localparam int          BIT_A_SYSCLK   = 7;
  localparam int          BIT_A_VREF     = 6;
  localparam int          BIT_A_VDET     = 5;
  localparam int          BIT_A_CRC      = 4;
  localparam int          BIT_A_SCAN     = 3;
  localparam int          BIT_A_REFCLK   = 1;
  localparam int          BIT_A_IOC      = 0;
  localparam int          BIT_B_CMP      = 7;
  localparam int          BIT_B_ZCD      = 6;
  localparam int          BIT_B_SMT      = 5;
  localparam int          BIT_C_CCP      = 7;
  localparam int          BIT_C_CWG      = 6;
  localparam int          BIT_C_DSM      = 5;
  localparam int          BIT_C_NCO      = 4;
  localparam int          BIT_C_ACT      = 3;
  localparam int          BIT_C_DAC1     = 2;
  localparam int          BIT_C_ADC      = 1;
  localparam int          BIT_C_CMP      = 0;
  localparam int          BIT_D_UART2    = 7;
  localparam int          BIT_D_UART1    = 6;
  localparam int          BIT_D_SPI2     = 5;
  localparam int          BIT_D_SPI1     = 4;
  localparam int          BIT_D_I2C      = 3;
  localparam int          BIT_E_UART3    = 0;
  localparam int          BIT_F_DAC2     = 1;
  localparam int          BIT_F_DMA4     = 0;
  localparam int          CLK_MHZ        = 125;
  localparam int          ENABLE_HOLD_CY = 2;
  localparam logic [1:0]  HOLD_LOAD      = 2'(ENABLE_HOLD_CY);
endpackage : pmdb_pkg

// File: pmdb_bank.sv
/*
  Peripheral module disable bank: six byte registers whose bits switch
  peripherals off and hold them in reset.
  Assumes a plain register port on clk_sys, read data one cycle later,
  and a synchronous zero-cross configuration fuse input.
*/
// Our own choice: strobed register access.
`timescale 1ns/10ps
module pmdb_bank
  import pmdb_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              zcd_fuse_off,
  output logic                   periph_sysclk_net_off,
  output logic                   voltage_ref_off,
  output logic                   volt_detect_off,
  output logic                   checksum_unit_off,
  output logic                   memory_scanner_off,
  output logic                   ref_clock_out_off,
  output logic                   pin_change_irq_off,
  output logic                   comparator_one_off,
  output logic                   zero_cross_off,
  output logic                   signal_meas_timer_off,
  output logic      [4:0]        timer_n_off,
  output logic                   capture_compare_one_off,
  output logic                   waveform_gen_one_off,
  output logic                   signal_modulator_off,
  output logic                   controlled_osc_one_off,
  output logic                   clock_tuning_off,
  output logic                   dac_first_off,
  output logic                   dac_second_off,
  output logic                   adc_unit_off,
  output logic      [2:0]        uart_n_off,
  output logic                   spi_first_off,
  output logic                   spi_second_off,
  output logic                   i2c_first_off,
  output logic                   pwm_first_off,
  output logic                   pwm_second_off,
  output logic                   pwm_third_off,
  output logic      [3:0]        dma_channel_n_off,
  output logic                   dma_channel_four_off,
  output logic      [3:0]        logic_cell_n_off,
  output logic                   periph_settling
);

  logic [7:0] module_disable_ctrl_a;
  logic [7:0] module_disable_ctrl_b;
  logic [7:0] module_disable_ctrl_c;
  logic [7:0] module_disable_ctrl_d;
  logic [7:0] module_disable_ctrl_e;
  logic [7:0] module_disable_ctrl_f;
  logic [1:0] hold_cnt;
  logic [7:0] next_rdata;
  logic       any_clear;

  function automatic logic [7:0] cleared_bits(input logic [7:0] old_v,
                                              input logic [7:0] new_v);
    cleared_bits = old_v & ~new_v;
  endfunction : cleared_bits

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      module_disable_ctrl_a <= RST_CTRL;
      module_disable_ctrl_b <= RST_CTRL;
      module_disable_ctrl_c <= RST_CTRL;
      module_disable_ctrl_d <= RST_CTRL;
      module_disable_ctrl_e <= RST_CTRL;
      module_disable_ctrl_f <= RST_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == OFS_CTRL_A) begin
        module_disable_ctrl_a <= reg_wdata & MASK_CTRL_A;
      end else if (reg_addr == OFS_CTRL_B) begin
        module_disable_ctrl_b <= reg_wdata;
      end else if (reg_addr == OFS_CTRL_C) begin
        module_disable_ctrl_c <= reg_wdata;
      end else if (reg_addr == OFS_CTRL_D) begin
        module_disable_ctrl_d <= reg_wdata;
      end else if (reg_addr == OFS_CTRL_E) begin
        module_disable_ctrl_e <= reg_wdata;
      end else if (reg_addr == OFS_CTRL_F) begin
        module_disable_ctrl_f <= reg_wdata & MASK_CTRL_F;
      end
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (reg_addr == OFS_CTRL_A) begin
      next_rdata = module_disable_ctrl_a;
    end else if (reg_addr == OFS_CTRL_B) begin
      next_rdata = module_disable_ctrl_b;
    end else if (reg_addr == OFS_CTRL_C) begin
      next_rdata = module_disable_ctrl_c;
    end else if (reg_addr == OFS_CTRL_D) begin
      next_rdata = module_disable_ctrl_d;
    end else if (reg_addr == OFS_CTRL_E) begin
      next_rdata = module_disable_ctrl_e;
    end else if (reg_addr == OFS_CTRL_F) begin
      next_rdata = module_disable_ctrl_f;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

  always_comb begin
    any_clear = 1'b0;
    if (reg_wr) begin
      if (reg_addr == OFS_CTRL_A) begin
        any_clear = |cleared_bits(module_disable_ctrl_a, reg_wdata & MASK_CTRL_A);
      end else if (reg_addr == OFS_CTRL_B) begin
        any_clear = |cleared_bits(module_disable_ctrl_b, reg_wdata);
      end else if (reg_addr == OFS_CTRL_C) begin
        any_clear = |cleared_bits(module_disable_ctrl_c, reg_wdata);
      end else if (reg_addr == OFS_CTRL_D) begin
        any_clear = |cleared_bits(module_disable_ctrl_d, reg_wdata);
      end else if (reg_addr == OFS_CTRL_E) begin
        any_clear = |cleared_bits(module_disable_ctrl_e, reg_wdata);
      end else if (reg_addr == OFS_CTRL_F) begin
        any_clear = |cleared_bits(module_disable_ctrl_f, reg_wdata & MASK_CTRL_F);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_cnt <= 2'h0;
    end else if (any_clear) begin
      hold_cnt <= HOLD_LOAD;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  assign periph_settling = (hold_cnt != 2'h0);

  assign periph_sysclk_net_off   = module_disable_ctrl_a[BIT_A_SYSCLK];
  assign voltage_ref_off         = module_disable_ctrl_a[BIT_A_VREF];
  assign volt_detect_off         = module_disable_ctrl_a[BIT_A_VDET];
  assign checksum_unit_off       = module_disable_ctrl_a[BIT_A_CRC];
  assign memory_scanner_off      = module_disable_ctrl_a[BIT_A_SCAN];
  assign ref_clock_out_off       = module_disable_ctrl_a[BIT_A_REFCLK];
  assign pin_change_irq_off      = module_disable_ctrl_a[BIT_A_IOC];
  assign comparator_one_off      = module_disable_ctrl_b[BIT_B_CMP] |
                                   module_disable_ctrl_c[BIT_C_CMP];
  assign zero_cross_off          = module_disable_ctrl_b[BIT_B_ZCD] | zcd_fuse_off;
  assign signal_meas_timer_off   = module_disable_ctrl_b[BIT_B_SMT];
  assign timer_n_off             = module_disable_ctrl_b[4:0];
  assign capture_compare_one_off = module_disable_ctrl_c[BIT_C_CCP];
  assign waveform_gen_one_off    = module_disable_ctrl_c[BIT_C_CWG];
  assign signal_modulator_off    = module_disable_ctrl_c[BIT_C_DSM];
  assign controlled_osc_one_off  = module_disable_ctrl_c[BIT_C_NCO];
  assign clock_tuning_off        = module_disable_ctrl_c[BIT_C_ACT];
  assign dac_first_off           = module_disable_ctrl_c[BIT_C_DAC1];
  assign adc_unit_off            = module_disable_ctrl_c[BIT_C_ADC];
  assign uart_n_off              = {module_disable_ctrl_e[BIT_E_UART3],
                                    module_disable_ctrl_d[BIT_D_UART2],
                                    module_disable_ctrl_d[BIT_D_UART1]};
  assign spi_second_off          = module_disable_ctrl_d[BIT_D_SPI2];
  assign spi_first_off           = module_disable_ctrl_d[BIT_D_SPI1];
  assign i2c_first_off           = module_disable_ctrl_d[BIT_D_I2C];
  assign pwm_third_off           = module_disable_ctrl_d[2];
  assign pwm_second_off          = module_disable_ctrl_d[1];
  assign pwm_first_off           = module_disable_ctrl_d[0];
  assign dma_channel_n_off       = {module_disable_ctrl_f[BIT_F_DMA4],
                                    module_disable_ctrl_e[7:5]};
  assign dma_channel_four_off    = module_disable_ctrl_f[BIT_F_DMA4];
  assign logic_cell_n_off        = module_disable_ctrl_e[4:1];
  assign dac_second_off          = module_disable_ctrl_f[BIT_F_DAC2];

  a_reset_clears: assert property (@(posedge clk_sys)
    rst |=> (module_disable_ctrl_b == 8'h00) && !comparator_one_off)
    else $error("disable bits not zero after reset");

  a_reset_idle: assert property (@(posedge clk_sys)
    rst |=> (reg_rdata == READ_ZERO) && !periph_settling && (timer_n_off == 5'h00) &&
            (dma_channel_n_off == 4'h0) && (uart_n_off == 3'h0))
    else $error("outputs not idle after reset");

  a_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_F) |=> module_disable_ctrl_f[7:2] == 6'h00)
    else $error("unimplemented bits of register f set");

  a_reg_f_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_F) |=>
      ({dac_second_off, dma_channel_four_off} == $past(reg_wdata[1:0])) &&
      (dma_channel_n_off[3] == $past(reg_wdata[0])))
    else $error("register f disables not written");

  a_gap_zero: assert property (@(posedge clk_sys) disable iff (rst)
    reg_wr |=> !module_disable_ctrl_a[2])
    else $error("unused bit of register a set");

  a_ctrl_a_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_A) |=>
      {periph_sysclk_net_off, voltage_ref_off} == $past(reg_wdata[7:6]))
    else $error("register a disables not written");

  a_timer_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_B) |=> timer_n_off == $past(reg_wdata[4:0]))
    else $error("timer disables not written");

  a_zcd_fuse: assert property (@(posedge clk_sys) disable iff (rst)
    zcd_fuse_off |-> zero_cross_off)
    else $error("zero-cross not off under fuse");

  a_zcd_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_B && reg_wdata[BIT_B_ZCD]) |=> zero_cross_off)
    else $error("zero-cross disable not written");

  a_adc_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_C) |=> adc_unit_off == $past(reg_wdata[1]))
    else $error("adc disable not written");

  a_capture_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_C) |=> capture_compare_one_off == $past(reg_wdata[7]))
    else $error("capture compare disable not written");

  a_c_kept: assert property (@(posedge clk_sys) disable iff (rst)
    !(reg_wr && reg_addr == OFS_CTRL_C) |=> $stable(module_disable_ctrl_c))
    else $error("register c changed without its write");

  a_read_back: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_rd && reg_addr == OFS_CTRL_D && !reg_wr) |=>
      reg_rdata == {uart_n_off[1:0], spi_second_off, spi_first_off,
                    i2c_first_off, pwm_third_off, pwm_second_off, pwm_first_off})
    else $error("register d read back wrong");

  a_uart_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_D) |=> uart_n_off[1:0] == $past(reg_wdata[7:6]))
    else $error("uart disables not written");

  a_pwm_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_D) |=>
      {pwm_third_off, pwm_second_off, pwm_first_off} == $past(reg_wdata[2:0]))
    else $error("pwm disables not written");

  a_dma_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_E) |=> dma_channel_n_off[2:0] == $past(reg_wdata[7:5]))
    else $error("dma disables not written");

  a_cell_write: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == OFS_CTRL_E) |=>
      {logic_cell_n_off, uart_n_off[2]} == $past(reg_wdata[4:0]))
    else $error("logic cell disables not written");

  a_cmp_either: assert property (@(posedge clk_sys) disable iff (rst)
    comparator_one_off == (module_disable_ctrl_b[7] || module_disable_ctrl_c[0]))
    else $error("comparator disable mismatch");

  // Settle window length
  // Back-to-back clears reload the counter, so either of the last two may extend it
  a_settle_len: assert property (@(posedge clk_sys) disable iff (rst)
    any_clear |=> periph_settling [*2] ##1
      (!periph_settling || $past(any_clear) || $past(any_clear, 2)))
    else $error("settling window wrong length");

  a_settle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    (!any_clear && !periph_settling) |=> !periph_settling)
    else $error("settling window without a clearing write");

endmodule : pmdb_bank

// File: testbench.sv
/*
  Self-checking testbench for the module disable bank: register access,
  disable outputs, settling flag, fuse gating and reset.
  Assumes the bank alone on clk_sys, driven only through its own ports.
*/
`timescale 1ns/10ps
module testbench;
  import pmdb_pkg::*;
  logic              clk_sys      = 1'b0;
  logic              rst          = 1'b1;
  logic [ADDR_W-1:0] reg_addr     = '0;
  logic [DATA_W-1:0] reg_wdata    = '0;
  logic              reg_wr       = 1'b0;
  logic              reg_rd       = 1'b0;
  logic              zcd_fuse_off = 1'b0;
  wire  [DATA_W-1:0] reg_rdata;
  wire               settling;
  wire  [40:0]       outs;
  logic [7:0]        sh [6];
  logic [7:0]        pats [4]     = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  int                error_cnt    = 0;
  int                total_checks = 0;

  always #4 clk_sys = ~clk_sys;

  pmdb_bank u_pmdb_bank (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .zcd_fuse_off            (zcd_fuse_off),
    .periph_sysclk_net_off   (outs[40]),
    .voltage_ref_off         (outs[39]),
    .volt_detect_off         (outs[38]),
    .checksum_unit_off       (outs[37]),
    .memory_scanner_off      (outs[36]),
    .ref_clock_out_off       (outs[35]),
    .pin_change_irq_off      (outs[34]),
    .comparator_one_off      (outs[33]),
    .zero_cross_off          (outs[32]),
    .signal_meas_timer_off   (outs[31]),
    .timer_n_off             (outs[30:26]),
    .capture_compare_one_off (outs[25]),
    .waveform_gen_one_off    (outs[24]),
    .signal_modulator_off    (outs[23]),
    .controlled_osc_one_off  (outs[22]),
    .clock_tuning_off        (outs[21]),
    .dac_first_off           (outs[20]),
    .adc_unit_off            (outs[19]),
    .uart_n_off              (outs[18:16]),
    .spi_second_off          (outs[15]),
    .spi_first_off           (outs[14]),
    .i2c_first_off           (outs[13]),
    .pwm_third_off           (outs[12]),
    .pwm_second_off          (outs[11]),
    .pwm_first_off           (outs[10]),
    .dma_channel_n_off       (outs[9:6]),
    .dma_channel_four_off    (outs[5]),
    .dac_second_off          (outs[4]),
    .logic_cell_n_off        (outs[3:0]),
    .periph_settling         (settling)
  );

  task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Shadow copy keeps unimplemented bits at zero, like the bank
  task automatic upd(input logic [11:0] a, input logic [7:0] d);
    if (a >= OFS_CTRL_A && a <= OFS_CTRL_F) begin
      sh[a - OFS_CTRL_A] = d & (a == OFS_CTRL_A ? MASK_CTRL_A :
                                a == OFS_CTRL_F ? MASK_CTRL_F : 8'hFF);
    end
  endtask : upd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    upd(a, d);
  endtask : wr

  // Two writes with no idle cycle between the strobes
  task automatic wr_pair(input logic [11:0] a1, input logic [7:0] d1,
                         input logic [11:0] a2, input logic [7:0] d2);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a1;
    reg_wdata <= d1;
    @(posedge clk_sys);
    reg_addr  <= a2;
    reg_wdata <= d2;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    upd(a1, d1);
    upd(a2, d2);
  endtask : wr_pair

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk(41'(reg_rdata), 41'(exp));
  endtask : rd

  // Output levels follow the shadow registers with no extra delay
  task automatic check_out;
    #1 chk(outs, {sh[0][7:3], sh[0][1:0], sh[1][7] | sh[2][0], sh[1][6] | zcd_fuse_off,
                  sh[1][5:0], sh[2][7:1], sh[4][0], sh[3][7:6], sh[3][5:0], sh[5][0],
                  sh[4][7:5], sh[5][0], sh[5][1], sh[4][4:1]});
  endtask : check_out

  task automatic check_all;
    for (int i = 0; i < 6; i++) begin
      rd(OFS_CTRL_A + 12'(i), sh[i]);
    end
    check_out;
  endtask : check_all

  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    #200000;
    error_cnt++;
    results;
  end

  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    check_all;
    foreach (pats[p]) begin
      for (int i = 0; i < 6; i++) wr(OFS_CTRL_A + 12'(i), pats[p]);
      check_all;
    end
    wr(OFS_CTRL_B, 8'h80);
    check_out;
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_C, 8'h01);
    check_out;
    @(posedge clk_sys);
    zcd_fuse_off <= 1'b1;
    check_out;
    wr(OFS_CTRL_B, 8'h40);
    zcd_fuse_off <= 1'b0;
    check_out;
    // Unmapped places ignore writes and read zero
    wr(12'h062, 8'hFF);
    wr(12'h069, 8'hFF);
    check_out;
    rd(12'h062, READ_ZERO);
    rd(12'h069, READ_ZERO);
    wr(OFS_CTRL_C, 8'hFF);
    rd(OFS_CTRL_C, 8'hFF);
    @(posedge clk_sys);
    #1 chk(41'(reg_rdata), 41'(READ_ZERO));
    wr(OFS_CTRL_D, 8'hFF);
    #1 chk(41'(settling), 41'(1'b0));
    wr(OFS_CTRL_D, 8'h7F);
    #1 chk(41'(settling), 41'(1'b1));
    @(posedge clk_sys);
    #1 chk(41'(settling), 41'(1'b1));
    @(posedge clk_sys);
    #1 chk(41'(settling), 41'(1'b0));
    wr(OFS_CTRL_E, 8'hFF);
    wr_pair(OFS_CTRL_D, 8'h00, OFS_CTRL_E, 8'h00);
    #1 chk(41'(settling), 41'(1'b1));
    @(posedge clk_sys);
    #1 chk(41'(settling), 41'(1'b1));
    @(posedge clk_sys);
    #1 chk(41'(settling), 41'(1'b0));
    check_all;
    for (int i = 0; i < 6; i++) wr(OFS_CTRL_A + 12'(i), 8'hFF);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (sh[i]) sh[i] = 8'h00;
    check_all;
    results;
  end
endmodule : testbench
